/* rtl/ubg_core.sv */
// Functional notes
// - bit rate is fclk over twice k
// - divisor k is 8 to 255
// - receive latches timed by divisor counter
// - back-to-back frames gain two base clocks
// - receive timing restarts on each start bit
// - stopped clock freezes every register
// - stopped clock holds serial output level
// - two-stage transmit path with two flags
// - flags read 10, 11, 01 in streams
// - power enable low holds base clock low
// - base clock is system clock over 2^n
// - separate divisor counters for tx and rx
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module ubg_core (
  input  wire logic       clock,          // 200 MHz system clock
  input  wire logic       rst,            // synchronous, active high
  input  wire logic       clock_stop,     // clock supply to the unit stopped
  input  wire logic [2:0] addr,           // register index
  input  wire logic [7:0] wdata,          // write data
  input  wire logic       wr,             // write strobe
  input  wire logic       rd,             // read strobe
  output logic      [7:0] rdata,          // read data, cycle after rd
  output logic            serial_out_pin, // transmit line
  input  wire logic       serial_in,      // receive line, asynchronous
  output logic            irq             // level interrupt
);
  // -------------------------------------------------------------------
  // types and helpers
  // -------------------------------------------------------------------
  typedef enum {T_IDLE, T_SEND, T_GAP} ubg_tx_t;
  typedef enum {R_IDLE, R_RECV} ubg_rx_t;

  // prohibited divisor codes act as the smallest legal one
  function automatic logic [7:0] ubg_clamp_k(input logic [7:0] v);
    return (v < ubg_pkg::K_MIN) ? ubg_pkg::K_MIN : v;
  endfunction

  // prohibited select codes (upper bits both set) act as the slowest
  function automatic logic [3:0] ubg_clamp_sel(input logic [3:0] v);
    return (v > ubg_pkg::SEL_MAX) ? ubg_pkg::SEL_MAX : v;
  endfunction

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  ubg_pkg::ubg_cfg_t    cfg;        // software configuration
  ubg_pkg::ubg_txflag_t flags;      // two-stage transmit status
  logic [7:0]           tx_hold;    // holding buffer contents
  logic [8:0]           tx_shift;   // stop plus data still to go
  logic [3:0]           tx_bits;    // bits left in this frame
  logic                 tx_phase;   // second half of bit when set
  logic [1:0]           gap_cnt;    // base clocks of stretch done
  ubg_tx_t              tx_state;   // transmit sequencer
  ubg_rx_t              rx_state;   // receive sequencer
  logic [4:0]           rx_halves;  // half periods since start edge
  logic [7:0]           rx_shift;   // incoming bits, lsb first
  logic [7:0]           rx_data;    // last complete byte
  logic [1:0]           ev_stat;    // sticky events
  logic [1:0]           ev_mask;    // event enables
  logic [10:0]          pre;        // base clock prescaler
  logic [2:0]           in_sync;    // pin synchroniser chain
  logic                 pin_level;  // debounced pin level
  logic                 samp;       // last base-clock sample
  logic                 rx_line;    // noise-filtered line
  logic                 rx_line_d;  // for start edge detection

  // -------------------------------------------------------------------
  // base clock
  // -------------------------------------------------------------------
  logic [3:0]  sel_eff;  // legal select code
  logic [10:0] pre_mask; // low n bits of prescaler
  logic        tick;     // one system clock wide base clock event
  logic        hold;     // everything frozen
  logic [7:0]  k_eff;    // legal divisor

  assign hold     = clock_stop;
  assign sel_eff  = ubg_clamp_sel(cfg.sel);
  assign k_eff    = ubg_clamp_k(cfg.k);
  assign pre_mask = 11'((12'h001 << sel_eff) - 12'h001);
  // fires once every 2^n system clocks, never while the unit is off
  assign tick     = cfg.power && !hold && ((pre & pre_mask) == pre_mask);

  // prescaler sits at zero while unpowered so the base clock stays low
  always_ff @(posedge clock) begin
    if (rst || !cfg.power) begin
      pre <= '0;
    end else if (!hold) begin
      pre <= pre + 11'h001;
    end
  end

  // -------------------------------------------------------------------
  // configuration registers
  // -------------------------------------------------------------------
  // writes landing while the clock is stopped are lost, as in silicon
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg     <= '{power: 1'b0, tx_en: 1'b0, rx_en: 1'b0,
                   sel: ubg_pkg::RST_CLKSEL, k: ubg_pkg::RST_DIV};
      ev_mask <= '0;
    end else if (!hold && wr) begin
      case (addr)
        ubg_pkg::ADDR_MODE: begin
          cfg.power <= wdata[ubg_pkg::POS_POWER];
          cfg.tx_en <= wdata[ubg_pkg::POS_TXEN];
          cfg.rx_en <= wdata[ubg_pkg::POS_RXEN];
        end
        ubg_pkg::ADDR_CLKSEL: cfg.sel <= wdata[3:0];
        ubg_pkg::ADDR_DIV:    cfg.k   <= wdata;
        ubg_pkg::ADDR_IRQMSK: ev_mask <= wdata[1:0];
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // transmit side
  // -------------------------------------------------------------------
  logic tx_half;  // half bit elapsed
  logic tx_load;  // move holding buffer into shift register
  logic tx_done;  // stop bit finished
  logic tx_write; // software fills holding buffer
  logic tx_run;   // transmitter enabled

  assign tx_run   = cfg.power && cfg.tx_en;
  assign tx_write = !hold && wr && (addr == ubg_pkg::ADDR_TXBUF) && tx_run && !flags.buf_full;
  assign tx_load  = !hold && tx_run && flags.buf_full &&
                    ((tx_state == T_IDLE) ||
                     (tx_state == T_GAP && tick && gap_cnt == ubg_pkg::GAP_TICKS - 2'h1));
  assign tx_done  = (tx_state == T_SEND) && tx_half && tx_phase && (tx_bits == 4'h1);

  // own divisor counter for transmit, restarted at every frame
  ubg_divider #(.W(8)) u_tx_div (
    .clock (clock),
    .rst   (rst),
    .hold  (hold),
    .clear (tx_load || !tx_run),
    .tick  (tick),
    .k     (k_eff),
    .half  (tx_half)
  );

  // holding buffer and its flag; the load clears it, a write sets it
  always_ff @(posedge clock) begin
    if (rst || !tx_run) begin
      flags.buf_full <= 1'b0;
      tx_hold        <= ubg_pkg::RST_ZERO;
    end else if (tx_write) begin
      flags.buf_full <= 1'b1;
      tx_hold        <= wdata;
    end else if (tx_load) begin
      flags.buf_full <= 1'b0;
    end
  end

  // frame sequencer; busy stays set through the stretch when chaining
  always_ff @(posedge clock) begin
    if (rst || !tx_run) begin
      tx_state         <= T_IDLE;
      flags.shift_busy <= 1'b0;
      serial_out_pin   <= 1'b1;
      tx_shift         <= '1;
      tx_bits          <= '0;
      tx_phase         <= 1'b0;
      gap_cnt          <= '0;
    end else if (!hold) begin
      if (tx_load) begin
        tx_state         <= T_SEND;
        flags.shift_busy <= 1'b1;
        serial_out_pin   <= 1'b0; // start bit
        tx_shift         <= {1'b1, tx_hold};
        tx_bits          <= ubg_pkg::FRAME_BITS;
        tx_phase         <= 1'b0;
      end else begin
        case (tx_state)
          T_SEND: begin
            if (tx_half) begin
              tx_phase <= !tx_phase;
              if (tx_phase) begin
                tx_bits <= tx_bits - 4'h1;
                if (tx_done) begin
                  // next byte waiting: stretch the idle gap first
                  tx_state         <= flags.buf_full ? T_GAP : T_IDLE;
                  flags.shift_busy <= flags.buf_full;
                  gap_cnt          <= '0;
                end else begin
                  serial_out_pin <= tx_shift[0];
                  tx_shift       <= {1'b1, tx_shift[8:1]};
                end
              end
            end
          end
          T_GAP: begin
            if (tick) begin
              gap_cnt <= gap_cnt + 2'h1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // -------------------------------------------------------------------
  // receive side
  // -------------------------------------------------------------------
  logic rx_run;   // receiver enabled
  logic rx_start; // falling edge of filtered line while idle
  logic rx_half;  // half bit elapsed
  logic rx_latch; // middle of a bit

  assign rx_run   = cfg.power && cfg.rx_en;
  assign rx_start = !hold && rx_run && (rx_state == R_IDLE) && rx_line_d && !rx_line;
  assign rx_latch = (rx_state == R_RECV) && rx_half && !rx_halves[0];

  // three flip-flops; only the last two decide the level
  always_ff @(posedge clock) begin
    if (rst) begin
      in_sync   <= 3'h7;
      pin_level <= 1'b1;
    end else if (!hold) begin
      in_sync <= {in_sync[1:0], serial_in};
      if (in_sync[1] == in_sync[2]) begin
        pin_level <= in_sync[2];
      end
    end
  end

  // base-clock match filter: two equal samples change the line
  always_ff @(posedge clock) begin
    if (rst || !cfg.power) begin
      samp      <= 1'b1;
      rx_line   <= 1'b1;
      rx_line_d <= 1'b1;
    end else if (!hold) begin
      rx_line_d <= rx_line;
      if (tick) begin
        samp <= pin_level;
        if (samp == pin_level) begin
          rx_line <= pin_level;
        end
      end
    end
  end

  // own divisor counter for receive, restarted on the start edge
  ubg_divider #(.W(8)) u_rx_div (
    .clock (clock),
    .rst   (rst),
    .hold  (hold),
    .clear (rx_start || !rx_run),
    .tick  (tick),
    .k     (k_eff),
    .half  (rx_half)
  );

  // latch instants count half bits from the start edge, so a long
  // gap before the edge cannot skew them
  always_ff @(posedge clock) begin
    if (rst || !rx_run) begin
      rx_state  <= R_IDLE;
      rx_halves <= '0;
      rx_shift  <= ubg_pkg::RST_ZERO;
      rx_data   <= ubg_pkg::RST_ZERO;
    end else if (!hold) begin
      case (rx_state)
        R_IDLE: begin
          if (rx_start) begin
            rx_state  <= R_RECV;
            rx_halves <= '0;
          end
        end
        R_RECV: begin
          if (rx_half) begin
            rx_halves <= rx_halves + 5'h01;
          end
          if (rx_latch) begin
            if (rx_halves == '0 && rx_line) begin
              rx_state <= R_IDLE; // glitch, not a start bit
            end else if (rx_halves == ubg_pkg::RX_HALVES - 5'h01) begin
              rx_state <= R_IDLE; // stop bit middle
              rx_data  <= rx_shift;
            end else if (rx_halves != '0) begin
              rx_shift <= {rx_line, rx_shift[7:1]};
            end
          end
        end
        default: rx_state <= R_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // events, interrupt and read port
  // -------------------------------------------------------------------
  logic [1:0] ev_set; // this cycle's events
  logic       rx_end; // byte complete

  assign rx_end = rx_latch && !hold && (rx_halves == ubg_pkg::RX_HALVES - 5'h01);
  assign ev_set = {rx_end, tx_done && !hold};
  assign irq    = |(ev_stat & ev_mask);

  // a read clears, but an event in that same cycle survives
  always_ff @(posedge clock) begin
    if (rst) begin
      ev_stat <= '0;
    end else if (!hold) begin
      ev_stat <= (rd && addr == ubg_pkg::ADDR_IRQST) ? ev_set : (ev_stat | ev_set);
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= ubg_pkg::RST_ZERO;
    end else if (!hold) begin
      rdata <= ubg_pkg::RST_ZERO;
      if (rd) begin
        case (addr)
          ubg_pkg::ADDR_MODE:   rdata <= {cfg.power, cfg.tx_en, cfg.rx_en, 5'h00};
          ubg_pkg::ADDR_CLKSEL: rdata <= {4'h0, cfg.sel};
          ubg_pkg::ADDR_DIV:    rdata <= cfg.k;
          ubg_pkg::ADDR_RXBUF:  rdata <= rx_data;
          ubg_pkg::ADDR_TXSTAT: rdata <= {6'h00, flags};
          ubg_pkg::ADDR_IRQST:  rdata <= {6'h00, ev_stat};
          ubg_pkg::ADDR_IRQMSK: rdata <= {6'h00, ev_mask};
          default:              rdata <= ubg_pkg::RST_ZERO;
        endcase
      end
    end
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  property p_gate_low;
    @(posedge clock) disable iff (rst)
      !cfg.power |=> (pre == '0) && serial_out_pin && !flags.shift_busy;
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("base clock while off");

  property p_full_rate;
    @(posedge clock) disable iff (rst)
      (tick && sel_eff != 4'h0) |=> !tick || (sel_eff == 4'h0);
  endproperty
  a_full_rate: assert property (p_full_rate) else $error("divide by two broken");

  property p_k_floor;
    @(posedge clock) disable iff (rst)
      k_eff >= ubg_pkg::K_MIN;
  endproperty
  a_k_floor: assert property (p_k_floor) else $error("divisor below eight");

  property p_pin_hold;
    @(posedge clock) disable iff (rst)
      clock_stop |=> $stable(serial_out_pin);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("output moved while stopped");

  property p_state_hold;
    @(posedge clock) disable iff (rst)
      clock_stop |=> $stable(flags) && $stable(rx_halves) && $stable(ev_stat) && $stable(pre);
  endproperty
  a_state_hold: assert property (p_state_hold) else $error("state moved while stopped");

  property p_load_flags;
    @(posedge clock) disable iff (rst)
      tx_load |=> !flags.buf_full && flags.shift_busy && !serial_out_pin;
  endproperty
  a_load_flags: assert property (p_load_flags) else $error("flags wrong after load");

  property p_gap_idle;
    @(posedge clock) disable iff (rst)
      (tx_state == T_GAP) |-> serial_out_pin && flags.shift_busy && gap_cnt < ubg_pkg::GAP_TICKS;
  endproperty
  a_gap_idle: assert property (p_gap_idle) else $error("stretch gap broken");

  property p_latch_odd;
    @(posedge clock) disable iff (rst)
      rx_end |=> (rx_state == R_IDLE) && (rx_data == $past(rx_shift));
  endproperty
  a_latch_odd: assert property (p_latch_odd) else $error("latch off bit middle");

  property p_start_fresh;
    @(posedge clock) disable iff (rst)
      rx_start |=> (rx_state == R_RECV) && (rx_halves == '0);
  endproperty
  a_start_fresh: assert property (p_start_fresh) else $error("rx timing not restarted");
endmodule
`default_nettype wire

/* rtl/ubg_pkg.sv */
package ubg_pkg;
  // -------------------------------------------------------------------
  // register map (word index on the plain register port)
  // -------------------------------------------------------------------
  localparam logic [2:0] ADDR_MODE   = 3'h0; // serial_mode_register
  localparam logic [2:0] ADDR_CLKSEL = 3'h1; // clock_select_register
  localparam logic [2:0] ADDR_DIV    = 3'h2; // baud_divisor_register
  localparam logic [2:0] ADDR_TXBUF  = 3'h3; // tx_holding_buffer (write)
  localparam logic [2:0] ADDR_RXBUF  = 3'h4; // received byte (read)
  localparam logic [2:0] ADDR_TXSTAT = 3'h5; // tx_status_register
  localparam logic [2:0] ADDR_IRQST  = 3'h6; // sticky events, read clears
  localparam logic [2:0] ADDR_IRQMSK = 3'h7; // interrupt mask

  // -------------------------------------------------------------------
  // field positions and reset values
  // -------------------------------------------------------------------
  localparam int POS_POWER = 7; // unit_power_enable
  localparam int POS_TXEN  = 6; // transmit_enable_bit
  localparam int POS_RXEN  = 5; // receive_enable_bit
  localparam int POS_BFULL = 1; // tx_buffer_full_flag
  localparam int POS_SBUSY = 0; // tx_shift_busy_flag
  localparam int POS_EVTX  = 0; // frame sent event
  localparam int POS_EVRX  = 1; // byte received event
  localparam logic [7:0] RST_DIV    = 8'hff;
  localparam logic [3:0] RST_CLKSEL = 4'h0;
  localparam logic [7:0] RST_ZERO   = 8'h00;

  // -------------------------------------------------------------------
  // timing limits
  // -------------------------------------------------------------------
  localparam logic [7:0] K_MIN      = 8'h08; // smallest legal divisor
  localparam logic [3:0] SEL_MAX    = 4'hb;  // fxx/2048
  localparam logic [1:0] GAP_TICKS  = 2'h2;  // stretch between frames
  localparam logic [3:0] FRAME_BITS = 4'ha;  // start, 8 data, stop
  localparam logic [4:0] RX_HALVES  = 5'h13; // half periods to stop middle

  // -------------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------------
  typedef struct packed {
    logic       power;  // unit power enable, functional reset when low
    logic       tx_en;  // transmit enable
    logic       rx_en;  // receive enable
    logic [3:0] sel;    // base_clock_select
    logic [7:0] k;      // divisor_value_field
  } ubg_cfg_t;

  typedef struct packed {
    logic buf_full;     // holding buffer occupied
    logic shift_busy;   // shift register sending
  } ubg_txflag_t;
endpackage

/* rtl/ubg_divider.sv */
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------------
// 8-bit divisor counter, one per direction
// ---------------------------------------------------------------------
module ubg_divider #(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         hold,   // clock supply stopped
  input  wire logic         clear,  // restart the count
  input  wire logic         tick,   // base clock event
  input  wire logic [W-1:0] k,      // divisor, already clamped
  output logic              half    // one pulse every k base clocks
);
  logic [W-1:0] count; // base clocks since last pulse

  // two pulses make one bit, so the bit rate is fclk over 2k
  assign half = !hold && !clear && tick && (count == k - W'(1));

  // counter restarts on clear so each frame begins on a fresh grid
  always_ff @(posedge clock) begin
    if (rst) begin
      count <= '0;
    end else if (!hold) begin
      if (clear) begin
        count <= '0;
      end else if (tick) begin
        count <= half ? '0 : count + W'(1);
      end
    end
  end

  property p_clear;
    @(posedge clock) disable iff (rst)
      (clear && !hold) |=> (count == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("divider not cleared");

  property p_period;
    @(posedge clock) disable iff (rst)
      half |-> (count == k - W'(1)) && (k >= ubg_pkg::K_MIN);
  endproperty
  a_period: assert property (p_period) else $error("divider pulse off grid");
endmodule
`default_nettype wire

/* sim/ubg_remote.sv */
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------------
// remote transceiver on the far end of the line
// ---------------------------------------------------------------------
module ubg_remote (
  input  wire logic clock,
  input  wire logic line_in,
  output logic      line_out
);
  int         bit_clks = 256; // clocks per bit time
  int         hi_run   = 0;   // clocks the line has been high
  int         gap_seen = 0;   // idle time before the latest start
  int         got_cnt  = 0;   // frames caught with a good stop bit
  logic [7:0] got_byte;       // last byte caught
  initial line_out = 1'b1;    // idle high

  // idle run counter, gives the stretched gap between frames
  always @(posedge clock) begin
    hi_run <= line_in ? hi_run + 1 : 0;
  end

  // frame catcher: resyncs on each start edge, samples mid-bit
  always begin
    @(negedge line_in);
    @(posedge clock);
    gap_seen = hi_run; // read a cycle late to dodge the update race
    repeat (bit_clks / 2 - 1) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_clks) @(posedge clock);
      got_byte[i] = line_in; // lsb first
    end
    repeat (bit_clks) @(posedge clock);
    if (line_in) begin
      got_cnt++;
    end
  end

  // sender: start, 8 data lsb first, stop; drive after an edge
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (bit_clks) @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int TK  = 16;          // base tick: sel 4 keeps it at 12.5 MHz
  localparam int BIT = 2 * 8 * TK;  // clocks per bit at k = 8
  logic       clock      = 1'b0;
  logic       rst        = 1'b1;
  logic       clock_stop = 1'b0;
  logic [2:0] addr       = 3'h0;
  logic [7:0] wdata      = 8'h00;
  logic       wr         = 1'b0;
  logic       rd         = 1'b0;
  logic [7:0] rdata;
  logic       serial_out_pin;
  logic       serial_in;
  logic       irq;
  int         failures   = 0;
  int         n_checks   = 0;
  int         n;

  ubg_core uut (.clock(clock), .rst(rst), .clock_stop(clock_stop), .addr(addr), .wdata(wdata), .wr(wr),
                .rd(rd), .rdata(rdata), .serial_out_pin(serial_out_pin), .serial_in(serial_in), .irq(irq));
  ubg_remote remote (.clock(clock), .line_in(serial_out_pin), .line_out(serial_in));

  // ---------------------------------------------------------------------
  // clock and shared tasks
  // ---------------------------------------------------------------------
  initial begin
    forever #2.5 clock = ~clock;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe; an edge passes first so back-to-back writes never
  // lower and raise the strobe in one time step
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rreg(input logic [2:0] a, output logic [7:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    d = rdata;
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rreg(a, d);
    chk(16'(d), 16'(exp));
  endtask

  // bounded wait for the remote end to catch frames
  task automatic wait_frames(input int cnt);
    for (int i = 0; i < 8000 && remote.got_cnt < cnt; i++) @(posedge clock);
    chk(16'(remote.got_cnt), 16'(cnt));
  endtask

  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset;
    rchk(ubg_pkg::ADDR_MODE, 8'h00);
    rchk(ubg_pkg::ADDR_CLKSEL, 8'h00);
    rchk(ubg_pkg::ADDR_DIV, 8'hff);
    rchk(ubg_pkg::ADDR_IRQMSK, 8'h00);
    wreg(ubg_pkg::ADDR_TXSTAT, 8'hff); // read-only place
    wreg(ubg_pkg::ADDR_TXBUF, 8'h55); // refused while tx disabled
    rchk(ubg_pkg::ADDR_TXSTAT, 8'h00);
    chk(16'(serial_out_pin), 16'h1);
    $display("reset test done");
  endtask

  task automatic t_tx_single;
    wreg(ubg_pkg::ADDR_CLKSEL, 8'h04);
    wreg(ubg_pkg::ADDR_DIV, 8'h08);
    wreg(ubg_pkg::ADDR_IRQMSK, 8'h03);
    wreg(ubg_pkg::ADDR_MODE, 8'he0);
    n = remote.got_cnt;
    wreg(ubg_pkg::ADDR_TXBUF, 8'ha5);
    rchk(ubg_pkg::ADDR_TXSTAT, 8'h02);
    rchk(ubg_pkg::ADDR_TXSTAT, 8'h01);
    wait_frames(n + 1);
    chk(16'(remote.got_byte), 16'h00a5);
    repeat (BIT) @(posedge clock);
    chk(16'(irq), 16'h1);
    rchk(ubg_pkg::ADDR_TXSTAT, 8'h00);
    rchk(ubg_pkg::ADDR_IRQST, 8'h01);
    chk(16'(irq), 16'h0);
    $display("single frame test done");
  endtask

  task automatic t_b2b;
    logic [7:0] v;
    n = remote.got_cnt;
    wreg(ubg_pkg::ADDR_TXBUF, 8'h11);
    for (int i = 0; i < 20; i++) begin
      rreg(ubg_pkg::ADDR_TXSTAT, v);
      if (v[1] === 1'b0) break;
    end
    wreg(ubg_pkg::ADDR_TXBUF, 8'h22);
    rchk(ubg_pkg::ADDR_TXSTAT, 8'h03);
    wait_frames(n + 2);
    chk(16'(remote.got_byte), 16'h0022);
    chk(16'(remote.gap_seen), 16'(BIT + 2 * TK));
    rchk(ubg_pkg::ADDR_TXSTAT, 8'h01);
    repeat (BIT) @(posedge clock);
    rchk(ubg_pkg::ADDR_IRQST, 8'h01);
    $display("back-to-back test done");
  endtask

  task automatic t_rx;
    n = remote.got_cnt;
    wreg(ubg_pkg::ADDR_TXBUF, 8'h5a);
    remote.send_byte(8'h3c);
    rchk(ubg_pkg::ADDR_RXBUF, 8'h3c);
    repeat (2 * TK + 5) @(posedge clock); // stretched idle gap
    remote.send_byte(8'hc3);
    rchk(ubg_pkg::ADDR_RXBUF, 8'hc3);
    chk(16'(remote.got_byte), 16'h005a);
    rchk(ubg_pkg::ADDR_IRQST, 8'h03);
    $display("duplex test done");
  endtask

  task automatic t_mask;
    wreg(ubg_pkg::ADDR_IRQMSK, 8'h02);
    n = remote.got_cnt;
    wreg(ubg_pkg::ADDR_TXBUF, 8'h0f);
    wait_frames(n + 1);
    repeat (BIT) @(posedge clock);
    chk(16'(irq), 16'h0); // masked event stays quiet
    wreg(ubg_pkg::ADDR_IRQMSK, 8'h03);
    @(posedge clock);
    chk(16'(irq), 16'h1);
    rchk(ubg_pkg::ADDR_IRQST, 8'h01);
    chk(16'(irq), 16'h0);
    $display("mask test done");
  endtask

  task automatic t_stop;
    wreg(ubg_pkg::ADDR_TXBUF, 8'h00);
    repeat (BIT * 3 / 2) @(posedge clock); // middle of data bit 0
    clock_stop <= 1'b1;
    for (int i = 0; i < 200; i++) begin
      @(posedge clock);
      chk(16'(serial_out_pin), 16'h0);
    end
    wreg(ubg_pkg::ADDR_DIV, 8'h20); // ignored while stopped
    clock_stop <= 1'b0;
    rchk(ubg_pkg::ADDR_DIV, 8'h08);
    rchk(ubg_pkg::ADDR_TXSTAT, 8'h01);
    wreg(ubg_pkg::ADDR_MODE, 8'h00);
    repeat (2) @(posedge clock);
    chk(16'(serial_out_pin), 16'h1);
    rchk(ubg_pkg::ADDR_TXSTAT, 8'h00);
    $display("clock stop test done");
  endtask

  // ---------------------------------------------------------------------
  // verdict, main sequence and watchdog
  // ---------------------------------------------------------------------
  task automatic give_verdict;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_tx_single;
    t_b2b;
    t_rx;
    t_mask;
    t_stop;
    give_verdict;
  end

  // about 20k cycles expected, so 60k means a hang
  initial begin
    repeat (60000) @(posedge clock);
    failures++;
    give_verdict;
  end
endmodule
`default_nettype wire
